// [logic/scc_slot_regs.sv]
// slot capability, control and status registers behind a wishbone slave
//
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "scc_regs.svh"

module scc_slot_regs
   import scc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [7:0] ADR_I,
   input wire logic [31:0] DAT_I,
   input wire logic [3:0] SEL_I,
   input wire logic WE_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic SLOT_IMPL,
   input wire logic DL_UP,
   input wire logic LOAD_STB,
   input wire logic [31:0] LOAD_DATA,
   input wire logic [3:0] SLOT_EVENT,
   output logic HOTPLUG_IRQ,
   output logic MSG_VALID,
   input wire logic MSG_READY,
   output logic [1:0] MSG_KIND,
   output logic [9:0] MSG_PAYLOAD
);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic req;
   logic wr_fire;
   logic hit_cap;
   logic hit_ctl;
   logic cap_wr;
   logic ctl_wr;
   logic sts_wr;

   assign req = CYC_I & STB_I;
   assign wr_fire = req & WE_I & ACK_O;
   assign hit_cap = (ADR_I == `SCC_OFF_CAP);
   assign hit_ctl = (ADR_I == `SCC_OFF_CTL);
   assign cap_wr = wr_fire & hit_cap & (|SEL_I) & SLOT_IMPL;
   assign ctl_wr = wr_fire & hit_ctl & (|SEL_I[1:0]);
   assign sts_wr = wr_fire & hit_ctl & SEL_I[2];

   // ----------------------------------------------------------------
   // capability register
   // ----------------------------------------------------------------
   logic [31:0] cap_lock_q;
   logic [7:0] plv_q;
   logic [1:0] pls_q;
   logic [31:0] cap_rd;
   logic [31:0] cap_wdata;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cap_lock_q <= `SCC_CAP_LOCK_RESET;
      end else if (LOAD_STB) begin
         cap_lock_q <= LOAD_DATA & `SCC_CAP_LOCK_MASK;
      end
   end

   always_comb begin
      cap_wdata = cap_rd;
      for (int b = 0; b < 4; b++) begin
         if (SEL_I[b]) begin
            cap_wdata[8*b +: 8] = DAT_I[8*b +: 8];
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         plv_q <= `SCC_PLV_RESET;
         pls_q <= `SCC_PLS_RESET;
      end else if (cap_wr) begin
         plv_q <= cap_wdata[`SCC_CAP_PLV_MSB:`SCC_CAP_PLV_LSB];
         pls_q <= cap_wdata[`SCC_CAP_PLS_MSB:`SCC_CAP_PLS_LSB];
      end
   end

   always_comb begin
      cap_rd = cap_lock_q
         & `SCC_CAP_LOCK_MASK;
      cap_rd[`SCC_CAP_PLV_MSB:`SCC_CAP_PLV_LSB] = plv_q;
      cap_rd[`SCC_CAP_PLS_MSB:`SCC_CAP_PLS_LSB] = pls_q;
      cap_rd[`SCC_CAP_NO_CC_NOTICE] = 1'b0;
      if (!SLOT_IMPL) begin
         cap_rd = 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   logic [5:0] en_q;
   logic [5:0] en_cap;
   logic [5:0] en_eff;
   logic [1:0] attn_q;
   logic attn_fit;

   assign attn_fit = cap_rd[`SCC_CAP_ATTN];
   // presence change enable has no capability behind it
   assign en_cap = {cap_rd[`SCC_CAP_HOTPLUG], cap_rd[`SCC_CAP_HOTPLUG],
      1'b1, cap_rd[`SCC_CAP_LATCH], cap_rd[`SCC_CAP_PWRCTL],
      cap_rd[`SCC_CAP_BUTTON]};
   assign en_eff = en_q & en_cap;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         en_q <= 6'h00;
      end else if (ctl_wr && SEL_I[0]) begin
         en_q <= (DAT_I[`SCC_CTL_EN_MSB:`SCC_CTL_EN_LSB] & en_cap)
            | (en_q & ~en_cap);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         attn_q <= `SCC_ATTN_RESET;
      end else if (ctl_wr && SEL_I[0] && attn_fit) begin
         attn_q <= DAT_I[`SCC_CTL_ATTN_MSB:`SCC_CTL_ATTN_LSB];
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   logic [4:0] sts_q;
   logic [4:0] sts_set;
   logic [4:0] sts_clr;
   logic cc_set;

   assign sts_set = {cc_set, SLOT_EVENT};
   assign sts_clr = sts_wr ? DAT_I[`SCC_STS_MSB:`SCC_STS_LSB] : 5'h00;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         sts_q <= 5'h00;
      end else begin
         sts_q <= (sts_q & ~sts_clr) | sts_set;
      end
   end

   // ----------------------------------------------------------------
   // hot-plug interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         HOTPLUG_IRQ <= 1'b0;
      end else begin
         HOTPLUG_IRQ <= en_eff[5]
            & (|(sts_q & en_eff[4:0]));
      end
   end

   // ----------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         ACK_O <= 1'b0;
         DAT_O <= 32'h00000000;
      end else begin
         ACK_O <= req & ~ACK_O;
         if (req && !ACK_O) begin
            if (hit_cap) begin
               DAT_O <= cap_rd;
            end else if (hit_ctl) begin
               DAT_O <= {11'h000, sts_q, 8'h00,
                  (attn_fit ? attn_q : 2'h0), en_eff};
            end else begin
               DAT_O <= 32'h00000000;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // message sender and command tracking
   // ----------------------------------------------------------------
   scc_msg_state_t state_q;
   logic pend_pwr_q;
   logic pend_attn_q;
   logic dl_up_q;
   logic take_pwr;
   logic take_attn;
   logic cmd_busy_q;
   logic attn_in_flight;

   assign take_attn = (state_q == MSG_IDLE) & pend_attn_q;
   assign take_pwr = (state_q == MSG_IDLE) & pend_pwr_q & ~pend_attn_q;
   assign attn_in_flight = (state_q == MSG_SEND)
      & (MSG_KIND == `SCC_MSG_ATTN_IND);

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         dl_up_q <= 1'b0;
      end else begin
         dl_up_q <= DL_UP;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         pend_pwr_q <= 1'b0;
         pend_attn_q <= 1'b0;
      end else begin
         pend_pwr_q <= (pend_pwr_q & ~take_pwr) | cap_wr
            | (DL_UP & ~dl_up_q & SLOT_IMPL);
         pend_attn_q <= (pend_attn_q & ~take_attn)
            | (ctl_wr & SEL_I[0] & attn_fit);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         state_q <= MSG_IDLE;
         MSG_VALID <= 1'b0;
         MSG_KIND <= 2'h0;
         MSG_PAYLOAD <= 10'h000;
      end else begin
         case (state_q)
            MSG_IDLE: begin
               if (take_attn) begin
                  MSG_VALID <= 1'b1;
                  MSG_KIND <= `SCC_MSG_ATTN_IND;
                  MSG_PAYLOAD <= {8'h00, attn_q};
                  state_q <= MSG_SEND;
               end else if (take_pwr) begin
                  MSG_VALID <= 1'b1;
                  MSG_KIND <= `SCC_MSG_POWER_LIMIT;
                  MSG_PAYLOAD <= {pls_q, plv_q};
                  state_q <= MSG_SEND;
               end
            end
            MSG_SEND: begin
               if (MSG_READY) begin
                  MSG_VALID <= 1'b0;
                  state_q <= MSG_IDLE;
               end
            end
            default: begin
               MSG_VALID <= 1'b0;
               state_q <= MSG_IDLE;
            end
         endcase
      end
   end

   // a command is done once its indicator message has left
   assign cc_set = cmd_busy_q & ~pend_attn_q & ~attn_in_flight & ~ctl_wr;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cmd_busy_q <= 1'b0;
      end else begin
         cmd_busy_q <= ctl_wr | (cmd_busy_q & ~cc_set);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_slot_gate_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (req && !ACK_O && hit_cap && !SLOT_IMPL) |=> (DAT_O == 32'h0))
      else $error("capability read nonzero without slot");

   a_no_cc_notice: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (req && !ACK_O && hit_cap) |=> !DAT_O[`SCC_CAP_NO_CC_NOTICE])
      else $error("no-completion-notice bit read as one");

   a_plv_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
      cap_wr && SEL_I[1] |=> plv_q[7:1] == $past(DAT_I[14:8]))
      else $error("power limit value not stored");

   a_pwr_msg_sent: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (cap_wr && state_q == MSG_IDLE && !pend_attn_q)
      |=> ##1 (MSG_VALID && MSG_KIND == `SCC_MSG_POWER_LIMIT))
      else $error("power limit message not sent after write");

   a_linkup_msg: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (DL_UP && !dl_up_q && SLOT_IMPL) |=> pend_pwr_q || take_pwr)
      else $error("link up did not queue power limit message");

   a_enable_masked: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (req && !ACK_O && hit_ctl && !cap_rd[`SCC_CAP_BUTTON])
      |=> !DAT_O[0])
      else $error("button enable read without capability");

   a_attn_reset: assert property (@(posedge CLOCK)
      $rose(RST_N) |-> attn_q == ATTN_OFF)
      else $error("attention state not off after reset");

   a_irq_cause: assert property (@(posedge CLOCK) disable iff (!RST_N)
      HOTPLUG_IRQ |-> $past(en_eff[5]) && $past(|(sts_q & en_eff[4:0])))
      else $error("interrupt without enabled cause");

   a_irq_raise: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (en_eff[5] && |(sts_q & en_eff[4:0])) |=> HOTPLUG_IRQ)
      else $error("interrupt missing for enabled event");

   a_cc_after_msg: assert property (@(posedge CLOCK) disable iff (!RST_N)
      cc_set |-> !pend_attn_q && !attn_in_flight)
      else $error("command done before indicator message left");

   a_cmd_done_bound: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (ctl_wr && !attn_fit && !pend_attn_q && !attn_in_flight)
      |=> ##1 sts_q[`SCC_STS_CMD_DONE])
      else $error("command done flag not set");

   a_lock_ignores_bus: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !LOAD_STB |=> cap_lock_q == $past(cap_lock_q))
      else $error("locked capability field changed by bus");

   a_msg_holds: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (MSG_VALID && !MSG_READY)
      |=> (MSG_VALID && $stable(MSG_KIND) && $stable(MSG_PAYLOAD)))
      else $error("message dropped or changed before acceptance");

   a_event_sets: assert property (@(posedge CLOCK) disable iff (!RST_N)
      SLOT_EVENT[0] |=> sts_q[0])
      else $error("button event flag not set");

   a_attn_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (ctl_wr && SEL_I[0] && attn_fit) |=> attn_q == $past(DAT_I[7:6]))
      else $error("attention state not stored");

   a_attn_read_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (req && !ACK_O && hit_ctl && !attn_fit) |=> DAT_O[7:6] == 2'h0)
      else $error("attention field read without indicator");

   a_pls_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (cap_wr && SEL_I[1] && SEL_I[2]) |=> pls_q == $past(DAT_I[16:15]))
      else $error("power limit scale not stored");

   a_cc_flag_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (sts_q[4] && !sts_clr[4]) |=> sts_q[4])
      else $error("command done flag lost without clear");

endmodule : scc_slot_regs
`default_nettype wire

// [logic/scc_regs.svh]
// offsets, field positions, reset values and codes of the slot register bank
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_OFF_CAP 8'h54
`define SCC_OFF_CTL 8'h58
`define SCC_CAP_LOCK_MASK 32'hfffa007f
`define SCC_CAP_NO_CC_NOTICE 18
`define SCC_CAP_PLV_LSB 7
`define SCC_CAP_PLV_MSB 14
`define SCC_CAP_PLS_LSB 15
`define SCC_CAP_PLS_MSB 16
`define SCC_CAP_BUTTON 0
`define SCC_CAP_PWRCTL 1
`define SCC_CAP_LATCH 2
`define SCC_CAP_ATTN 3
`define SCC_CAP_HOTPLUG 6
`define SCC_CTL_EN_LSB 0
`define SCC_CTL_EN_MSB 5
`define SCC_CTL_ATTN_LSB 6
`define SCC_CTL_ATTN_MSB 7
`define SCC_STS_LSB 16
`define SCC_STS_MSB 20
`define SCC_STS_CMD_DONE 4
`define SCC_PLV_RESET 8'h00
`define SCC_PLS_RESET 2'h0
`define SCC_ATTN_RESET 2'h3
`define SCC_CAP_LOCK_RESET 32'h00000000
`define SCC_MSG_POWER_LIMIT 2'h1
`define SCC_MSG_ATTN_IND 2'h2
`endif

// [logic/scc_pkg.sv]
// types shared by the slot register bank
package scc_pkg;
   typedef enum logic [1:0] {
      ATTN_RESERVED,
      ATTN_ON,
      ATTN_BLINK,
      ATTN_OFF
   } scc_attn_t;
   typedef enum {
      MSG_IDLE,
      MSG_SEND
   } scc_msg_state_t;
endpackage : scc_pkg

// [test/scc_msg_sink.sv]
// slot-side model that accepts power limit and indicator messages
`timescale 1ns/10ps
`default_nettype none
module scc_msg_sink (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic msg_valid,
   input wire logic [1:0] msg_kind,
   input wire logic [9:0] msg_payload,
   input wire logic [3:0] stall,
   output logic msg_ready,
   output logic [7:0] got_count,
   output logic [1:0] got_kind,
   output logic [9:0] got_payload
);
   logic [3:0] wait_q;
   // holds ready off for stall plus one cycles after an offer, then takes it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         msg_ready <= 1'b0;
         wait_q <= 4'h0;
         got_count <= 8'h00;
         got_kind <= 2'h0;
         got_payload <= 10'h000;
      end else if (msg_valid && msg_ready) begin
         msg_ready <= 1'b0;
         wait_q <= 4'h0;
         got_count <= got_count + 8'h01;
         got_kind <= msg_kind;
         got_payload <= msg_payload;
      end else if (msg_valid) begin
         msg_ready <= (wait_q >= stall);
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule : scc_msg_sink
`default_nettype wire

// [test/test_scc_slot_regs.sv]
// self-checking bench for the slot register bank
`timescale 1ns/10ps
`default_nettype none
`include "scc_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   mismatches++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_scc_slot_regs
   import scc_pkg::*;
;
   logic CLOCK, RST_N, WE_I, CYC_I, STB_I, ACK_O, SLOT_IMPL, DL_UP, LOAD_STB;
   logic HOTPLUG_IRQ, MSG_VALID, MSG_READY;
   logic [7:0] ADR_I, got_count, cnt;
   logic [31:0] DAT_I, DAT_O, LOAD_DATA, rdata;
   logic [3:0] SEL_I, SLOT_EVENT, stall;
   logic [1:0] MSG_KIND, got_kind;
   logic [9:0] MSG_PAYLOAD, got_payload;
   scc_attn_t codes [3] = '{ATTN_BLINK, ATTN_OFF, ATTN_ON};
   int mismatches, comparisons;
   scc_slot_regs u_scc_slot_regs (.CLOCK, .RST_N, .ADR_I, .DAT_I, .SEL_I,
      .WE_I, .CYC_I, .STB_I, .DAT_O, .ACK_O, .SLOT_IMPL, .DL_UP, .LOAD_STB,
      .LOAD_DATA, .SLOT_EVENT, .HOTPLUG_IRQ, .MSG_VALID, .MSG_READY,
      .MSG_KIND, .MSG_PAYLOAD);
   scc_msg_sink u_scc_msg_sink (.clock(CLOCK), .rst_n(RST_N),
      .msg_valid(MSG_VALID), .msg_kind(MSG_KIND), .msg_payload(MSG_PAYLOAD),
      .stall, .msg_ready(MSG_READY), .got_count, .got_kind, .got_payload);
   always #5 CLOCK = ~CLOCK;
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   // one classic wishbone cycle, entered just after a rising edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      ADR_I <= a;
      WE_I <= w;
      SEL_I <= s;
      DAT_I <= d;
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (ACK_O !== 1'b1 && n < 20);
      rdata = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      WE_I <= 1'b0;
      @(posedge CLOCK);
      if (n >= 20) begin
         mismatches++;
         stop_test();
      end
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      wb(a, 1'b1, s, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      wb(a, 1'b0, 4'hf, 32'h0);
   endtask : rd
   task automatic load(input logic [31:0] d);
      LOAD_DATA <= d;
      LOAD_STB <= 1'b1;
      @(posedge CLOCK);
      LOAD_STB <= 1'b0;
      @(posedge CLOCK);
   endtask : load
   task automatic pulse(input int i);
      SLOT_EVENT <= 4'h1 << i;
      @(posedge CLOCK);
      SLOT_EVENT <= 4'h0;
      @(posedge CLOCK);
   endtask : pulse
   task automatic wait_msg(input logic [7:0] c);
      int n;
      n = 0;
      while (got_count === c && n < 60) begin
         @(posedge CLOCK);
         n++;
      end
      if (n >= 60) begin
         mismatches++;
         stop_test();
      end
   endtask : wait_msg
   task automatic wait_irq(input logic e);
      for (int n = 0; n < 8 && HOTPLUG_IRQ !== e; n++) begin
         @(posedge CLOCK);
      end
   endtask : wait_irq
   task automatic t_reset();
      rd(`SCC_OFF_CAP);
      `CHK("cap", 32'h0, rdata)
      rd(`SCC_OFF_CTL);
      `CHK("ctl", 32'h0, rdata)
      rd(8'h40);
      `CHK("unmapped", 32'h0, rdata)
      load(32'hffffffff);
      rd(`SCC_OFF_CAP);
      `CHK("cap", `SCC_CAP_LOCK_MASK, rdata)
      `CHK("hi", 3'h5, rdata[19:17])
      `CHK("num", 13'h1fff, rdata[31:19])
   endtask : t_reset
   task automatic t_power();
      for (int i = 0; i < 4; i++) begin
         cnt = got_count;
         stall <= 4'(i * 3);
         wr(`SCC_OFF_CAP, 4'hf, {15'h0, i[1:0], 8'ha5, 7'h0});
         wait_msg(cnt);
         `CHK("kind", 2'h1, got_kind)
         `CHK("limit", {i[1:0], 8'ha5}, got_payload)
      end
      rd(`SCC_OFF_CAP);
      `CHK("cap", 32'hfffbd2ff, rdata)
      SLOT_IMPL <= 1'b0;
      @(posedge CLOCK);
      rd(`SCC_OFF_CAP);
      `CHK("noslot", 32'h0, rdata)
      SLOT_IMPL <= 1'b1;
      @(posedge CLOCK);
      cnt = got_count;
      DL_UP <= 1'b1;
      wait_msg(cnt);
      `CHK("linkup", {2'h3, 8'ha5}, got_payload)
   endtask : t_power
   task automatic t_ctl();
      stall <= 4'h9;
      for (int i = 0; i < 3; i++) begin
         cnt = got_count;
         wr(`SCC_OFF_CTL, 4'h5, {11'h0, 5'h1f, 8'h0, codes[i], 6'h3f});
         rd(`SCC_OFF_CTL);
         `CHK("early", 1'b0, rdata[20])
         wait_msg(cnt);
         `CHK("kind", 2'h2, got_kind)
         `CHK("attn", {8'h0, codes[i]}, got_payload)
         rd(`SCC_OFF_CTL);
         `CHK("en", 6'h3f, rdata[5:0])
         `CHK("ctl", codes[i], rdata[7:6])
         `CHK("done", 1'b1, rdata[20])
         wait_irq(1'b1);
         `CHK("irq", 1'b1, HOTPLUG_IRQ)
      end
   endtask : t_ctl
   task automatic t_events();
      stall <= 4'h0;
      for (int i = 0; i < 4; i++) begin
         wr(`SCC_OFF_CTL, 4'h4, 32'h001f0000);
         wait_irq(1'b0);
         `CHK("irq", 1'b0, HOTPLUG_IRQ)
         pulse(i);
         wait_irq(1'b1);
         `CHK("irq", 1'b1, HOTPLUG_IRQ)
         rd(`SCC_OFF_CTL);
         `CHK("flag", 1'b1, rdata[16 + i])
      end
      cnt = got_count;
      wr(`SCC_OFF_CTL, 4'h5, {11'h0, 5'h1f, 8'h0, ATTN_ON, 6'h1f});
      wait_msg(cnt);
      pulse(3);
      wait_irq(1'b1);
      `CHK("masked", 1'b0, HOTPLUG_IRQ)
      load(32'h00000040);
      rd(`SCC_OFF_CTL);
      `CHK("gated", 8'h18, rdata[7:0])
      cnt = got_count;
      wr(`SCC_OFF_CTL, 4'h5, 32'h00100018);
      rd(`SCC_OFF_CTL);
      `CHK("done", 1'b1, rdata[20])
      `CHK("nomsg", cnt, got_count)
   endtask : t_events
   initial begin
      {CLOCK, RST_N, WE_I, CYC_I, STB_I, DL_UP, LOAD_STB} = '0;
      {ADR_I, DAT_I, SEL_I, LOAD_DATA, SLOT_EVENT, stall} = '0;
      SLOT_IMPL = 1'b1;
      repeat (10) @(posedge CLOCK);
      RST_N <= 1'b1;
      @(posedge CLOCK);
      t_reset();
      t_power();
      t_ctl();
      t_events();
      stop_test();
   end
endmodule : test_scc_slot_regs
`default_nettype wire
